// ===== usbie_top.sv
// Interrupt-enable registers of a full-speed USB function controller.
// Assumes event pulses from the USB engine on ref_clk and a single-cycle register port.
`timescale 1ns/100ps
`default_nettype none
module usbie_top (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic out_ep1_event,
    input wire logic out_ep2_event,
    input wire logic out_ep3_event,
    input wire logic frame_start_event,
    input wire logic bus_reset_event,
    input wire logic resume_event,
    input wire logic suspend_event,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [7:0] out_en;
        logic [7:0] cmn_en;
        logic [7:0] rdata;
        logic irq;
    } usbie_state_t;

    usbie_state_t st_r;
    usbie_state_t st_nxt;
    logic [7:0] out_req;
    logic [7:0] cmn_req;
    logic [7:0] rd_mux;

    usbie_flag_if out_fl ();
    usbie_flag_if cmn_fl ();

    function automatic logic usbie_sel(input logic [7:0] addr, input logic [7:0] offset);
        usbie_sel = (addr == offset);
    endfunction : usbie_sel

    ////////////////////////////////////////////////////////////////////////////////
    // Flag banks. Events are recorded whatever the enables say.
    always_comb begin
        out_fl.set = 8'h00;
        out_fl.set[usbie_pkg::BIT_OUT1] = out_ep1_event;
        out_fl.set[usbie_pkg::BIT_OUT2] = out_ep2_event;
        out_fl.set[usbie_pkg::BIT_OUT3] = out_ep3_event;
        cmn_fl.set = 8'h00;
        cmn_fl.set[usbie_pkg::BIT_SUSPEND] = suspend_event;
        cmn_fl.set[usbie_pkg::BIT_RESUME] = resume_event;
        cmn_fl.set[usbie_pkg::BIT_BUS_RESET] = bus_reset_event;
        cmn_fl.set[usbie_pkg::BIT_FRAME_START] = frame_start_event;
        out_fl.clr = 8'h00;
        cmn_fl.clr = 8'h00;
        if (reg_wr && usbie_sel(reg_addr, usbie_pkg::OUT_FLAG_ADDR)) begin
            out_fl.clr = reg_wdata;
        end
        if (reg_wr && usbie_sel(reg_addr, usbie_pkg::CMN_FLAG_ADDR)) begin
            cmn_fl.clr = reg_wdata;
        end
    end

    usbie_flags #(
        .LIVE_MASK(usbie_pkg::OUT_LIVE_MASK)
    ) u_out_flags (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .fl(out_fl.bank)
    );

    usbie_flags #(
        .LIVE_MASK(usbie_pkg::CMN_LIVE_MASK)
    ) u_cmn_flags (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .fl(cmn_fl.bank)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Request gating. An enable only masks the request, never the flag.
    always_comb begin
        out_req = 8'h00;
        cmn_req = 8'h00;
        out_req[usbie_pkg::BIT_OUT3] = out_fl.flags[usbie_pkg::BIT_OUT3] & st_r.out_en[usbie_pkg::BIT_OUT3];
        out_req[usbie_pkg::BIT_OUT2] = out_fl.flags[usbie_pkg::BIT_OUT2] & st_r.out_en[usbie_pkg::BIT_OUT2];
        out_req[usbie_pkg::BIT_OUT1] = out_fl.flags[usbie_pkg::BIT_OUT1] & st_r.out_en[usbie_pkg::BIT_OUT1];
        cmn_req[usbie_pkg::BIT_FRAME_START] =
            cmn_fl.flags[usbie_pkg::BIT_FRAME_START] & st_r.cmn_en[usbie_pkg::BIT_FRAME_START];
        cmn_req[usbie_pkg::BIT_BUS_RESET] =
            cmn_fl.flags[usbie_pkg::BIT_BUS_RESET] & st_r.cmn_en[usbie_pkg::BIT_BUS_RESET];
        cmn_req[usbie_pkg::BIT_RESUME] =
            cmn_fl.flags[usbie_pkg::BIT_RESUME] & st_r.cmn_en[usbie_pkg::BIT_RESUME];
        cmn_req[usbie_pkg::BIT_SUSPEND] =
            cmn_fl.flags[usbie_pkg::BIT_SUSPEND] & st_r.cmn_en[usbie_pkg::BIT_SUSPEND];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer. Unmapped offsets read as zero.
    always_comb begin
        rd_mux = 8'h00;
        if (usbie_sel(reg_addr, usbie_pkg::OUT_EN_ADDR)) begin
            rd_mux = st_r.out_en & usbie_pkg::OUT_LIVE_MASK;
        end else if (usbie_sel(reg_addr, usbie_pkg::CMN_EN_ADDR)) begin
            rd_mux = st_r.cmn_en & usbie_pkg::CMN_LIVE_MASK;
        end else if (usbie_sel(reg_addr, usbie_pkg::OUT_FLAG_ADDR)) begin
            rd_mux = out_fl.flags;
        end else if (usbie_sel(reg_addr, usbie_pkg::CMN_FLAG_ADDR)) begin
            rd_mux = cmn_fl.flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state. Read data stand for one cycle only, then fall back to zero.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = usbie_pkg::RDATA_RESET;
        if (reg_rd) begin
            st_nxt.rdata = rd_mux;
        end
        if (reg_wr && usbie_sel(reg_addr, usbie_pkg::OUT_EN_ADDR)) begin
            st_nxt.out_en = reg_wdata & usbie_pkg::OUT_LIVE_MASK;
        end
        if (reg_wr && usbie_sel(reg_addr, usbie_pkg::CMN_EN_ADDR)) begin
            st_nxt.cmn_en = reg_wdata & usbie_pkg::CMN_LIVE_MASK;
        end
        // The output is registered, so it trails the flags by one cycle; this keeps irq glitch free.
        st_nxt.irq = (|out_req) | (|cmn_req);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_r <= '{
                out_en: usbie_pkg::OUT_EN_RESET,
                cmn_en: usbie_pkg::CMN_EN_RESET,
                rdata: usbie_pkg::RDATA_RESET,
                irq: 1'b0
            };
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign irq = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_quiet;
        ce && !reg_wr;
    endsequence

    sequence s_wr_cmn;
        ce && reg_wr && (reg_addr == usbie_pkg::CMN_EN_ADDR);
    endsequence

    sequence s_rd_cmn;
        ce && reg_rd && !reg_wr && (reg_addr == usbie_pkg::CMN_EN_ADDR);
    endsequence

    sequence s_wr_out;
        ce && reg_wr && (reg_addr == usbie_pkg::OUT_EN_ADDR);
    endsequence

    sequence s_rd_out;
        ce && reg_rd && !reg_wr && (reg_addr == usbie_pkg::OUT_EN_ADDR);
    endsequence

    property p_ep3_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        (ce && !reg_wr && out_ep3_event && st_r.out_en[usbie_pkg::BIT_OUT3]) ##1 s_quiet |=> irq;
    endproperty
    a_ep3_gate: assert property (p_ep3_gate) else $error("enabled OUT ep3 event gave no irq");

    property p_ep2_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        s_quiet and (out_fl.flags[usbie_pkg::BIT_OUT2] && st_r.out_en[usbie_pkg::BIT_OUT2]) |=> irq;
    endproperty
    a_ep2_gate: assert property (p_ep2_gate) else $error("enabled OUT ep2 flag gave no irq");

    property p_ep1_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && out_fl.flags[usbie_pkg::BIT_OUT1] && st_r.out_en[usbie_pkg::BIT_OUT1] |=> irq;
    endproperty
    a_ep1_gate: assert property (p_ep1_gate) else $error("enabled OUT ep1 flag gave no irq");

    property p_out_upper_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wr_out ##1 s_rd_out |=> (reg_rdata == ($past(reg_wdata, 2) & usbie_pkg::OUT_LIVE_MASK));
    endproperty
    a_out_upper_zero: assert property (p_out_upper_zero) else $error("OUT enable readback wrong");

    property p_sof_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && cmn_fl.flags[usbie_pkg::BIT_FRAME_START] && st_r.cmn_en[usbie_pkg::BIT_FRAME_START] |=> irq;
    endproperty
    a_sof_gate: assert property (p_sof_gate) else $error("enabled frame start flag gave no irq");

    property p_bus_reset_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        (ce && !reg_wr && bus_reset_event && st_r.cmn_en[usbie_pkg::BIT_BUS_RESET]) ##1 s_quiet |=> irq;
    endproperty
    a_bus_reset_gate: assert property (p_bus_reset_gate) else $error("enabled bus reset gave no irq");

    property p_resume_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && cmn_fl.flags[usbie_pkg::BIT_RESUME] && st_r.cmn_en[usbie_pkg::BIT_RESUME] |=> irq;
    endproperty
    a_resume_gate: assert property (p_resume_gate) else $error("enabled resume flag gave no irq");

    property p_suspend_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && cmn_fl.flags[usbie_pkg::BIT_SUSPEND] && st_r.cmn_en[usbie_pkg::BIT_SUSPEND] |=> irq;
    endproperty
    a_suspend_gate: assert property (p_suspend_gate) else $error("enabled suspend flag gave no irq");

    property p_cmn_upper_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wr_cmn ##1 s_rd_cmn |=> (reg_rdata[7:4] == 4'h0)
            && (reg_rdata == ($past(reg_wdata, 2) & usbie_pkg::CMN_LIVE_MASK));
    endproperty
    a_cmn_upper_zero: assert property (p_cmn_upper_zero) else $error("common enable readback wrong");

    property p_masked_quiet;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (st_r.out_en == 8'h00) && (st_r.cmn_en == 8'h00) |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("irq raised with all enables clear");

    property p_flag_kept_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && suspend_event && !st_r.cmn_en[usbie_pkg::BIT_SUSPEND] |=> cmn_fl.flags[usbie_pkg::BIT_SUSPEND];
    endproperty
    a_flag_kept_masked: assert property (p_flag_kept_masked) else $error("masked event not recorded");

    property p_rdata_one_cycle;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && !reg_rd ##1 ce |-> (reg_rdata == 8'h00);
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data held past its cycle");

    ////////////////////////////////////////////////////////////////////////////////
    // A lone flag behind a clear enable must keep irq low, since the other bank is empty.
    property p_ep3_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (out_fl.flags == 8'h08) && !st_r.out_en[usbie_pkg::BIT_OUT3]
            && (cmn_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_ep3_masked: assert property (p_ep3_masked) else $error("masked OUT ep3 flag raised irq");

    property p_ep2_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (out_fl.flags == 8'h04) && !st_r.out_en[usbie_pkg::BIT_OUT2]
            && (cmn_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_ep2_masked: assert property (p_ep2_masked) else $error("masked OUT ep2 flag raised irq");

    property p_ep1_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (out_fl.flags == 8'h02) && !st_r.out_en[usbie_pkg::BIT_OUT1]
            && (cmn_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_ep1_masked: assert property (p_ep1_masked) else $error("masked OUT ep1 flag raised irq");

    property p_sof_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (cmn_fl.flags == 8'h08) && !st_r.cmn_en[usbie_pkg::BIT_FRAME_START]
            && (out_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_sof_masked: assert property (p_sof_masked) else $error("masked frame start flag raised irq");

    property p_bus_reset_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (cmn_fl.flags == 8'h04) && !st_r.cmn_en[usbie_pkg::BIT_BUS_RESET]
            && (out_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_bus_reset_masked: assert property (p_bus_reset_masked) else $error("masked bus reset raised irq");

    property p_resume_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (cmn_fl.flags == 8'h02) && !st_r.cmn_en[usbie_pkg::BIT_RESUME]
            && (out_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_resume_masked: assert property (p_resume_masked) else $error("masked resume flag raised irq");

    property p_suspend_masked;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && (cmn_fl.flags == 8'h01) && !st_r.cmn_en[usbie_pkg::BIT_SUSPEND]
            && (out_fl.flags == 8'h00) |=> !irq;
    endproperty
    a_suspend_masked: assert property (p_suspend_masked) else $error("masked suspend flag raised irq");

    property p_out_wr_lands;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wr_out |=> (st_r.out_en == ($past(reg_wdata) & usbie_pkg::OUT_LIVE_MASK));
    endproperty
    a_out_wr_lands: assert property (p_out_wr_lands) else $error("OUT enable write wrong");

    property p_cmn_wr_lands;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wr_cmn |=> (st_r.cmn_en == ($past(reg_wdata) & usbie_pkg::CMN_LIVE_MASK));
    endproperty
    a_cmn_wr_lands: assert property (p_cmn_wr_lands) else $error("common enable write wrong");

    // A frozen cycle must hold every register, or a slow enable would corrupt state.
    property p_ce_freeze;
        @(posedge ref_clk) disable iff (!rst_b)
        rst_b && !ce |=> $stable(st_r) && $stable(reg_rdata) && $stable(irq);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

    property p_reset_values;
        @(posedge ref_clk)
        !rst_b |=> (st_r.out_en == usbie_pkg::OUT_EN_RESET) && (st_r.cmn_en == usbie_pkg::CMN_EN_RESET) && !irq;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("enable registers wrong after reset");

    property p_cmn_flag_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && reg_wr && (reg_addr == usbie_pkg::CMN_FLAG_ADDR)
            && reg_wdata[usbie_pkg::BIT_SUSPEND] && !suspend_event |=> !cmn_fl.flags[usbie_pkg::BIT_SUSPEND];
    endproperty
    a_cmn_flag_clear: assert property (p_cmn_flag_clear) else $error("written one left suspend flag set");

    property p_out_flag_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && reg_wr && (reg_addr == usbie_pkg::OUT_FLAG_ADDR)
            && reg_wdata[usbie_pkg::BIT_OUT1] && !out_ep1_event |=> !out_fl.flags[usbie_pkg::BIT_OUT1];
    endproperty
    a_out_flag_clear: assert property (p_out_flag_clear) else $error("written one left OUT ep1 flag set");

endmodule : usbie_top
`default_nettype wire

// ===== usbie_pkg.sv
// Constants for the USB interrupt-enable register block.
// Assumes an 8-bit register port with byte-wide registers at their own offsets.
package usbie_pkg;

    localparam int unsigned REG_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] OUT_FLAG_ADDR = 8'h04;
    localparam logic [7:0] CMN_FLAG_ADDR = 8'h06;
    localparam logic [7:0] OUT_EN_ADDR = 8'h09;
    localparam logic [7:0] CMN_EN_ADDR = 8'h0B;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] OUT_EN_RESET = 8'h0E;
    localparam logic [7:0] CMN_EN_RESET = 8'h06;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and implemented bits.
    localparam int unsigned BIT_OUT1 = 1;
    localparam int unsigned BIT_OUT2 = 2;
    localparam int unsigned BIT_OUT3 = 3;
    localparam int unsigned BIT_SUSPEND = 0;
    localparam int unsigned BIT_RESUME = 1;
    localparam int unsigned BIT_BUS_RESET = 2;
    localparam int unsigned BIT_FRAME_START = 3;
    localparam logic [7:0] OUT_LIVE_MASK = 8'h0E;
    localparam logic [7:0] CMN_LIVE_MASK = 8'h0F;

endpackage : usbie_pkg

// ===== usbie_flag_if.sv
// Carrier between the register logic and one sticky flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface usbie_flag_if;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] flags;
    modport bank (input set, input clr, output flags);
    modport ctrl (output set, output clr, input flags);
endinterface : usbie_flag_if
`default_nettype wire

// ===== usbie_flags.sv
// One bank of sticky event flags, set by hardware and cleared by writing a one.
// Assumes set and clear pulses come from logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module usbie_flags #(
    parameter logic [7:0] LIVE_MASK = 8'hFF
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    usbie_flag_if.bank fl
);

    typedef struct packed {
        logic [7:0] flags;
    } usbie_flag_state_t;

    usbie_flag_state_t st_r;
    usbie_flag_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // A set in the same cycle as its clear wins, so no event is lost.
    always_comb begin
        st_nxt = st_r;
        st_nxt.flags = ((st_r.flags & ~fl.clr) | fl.set) & LIVE_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_r <= '{flags: usbie_pkg::FLAG_RESET};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign fl.flags = st_r.flags;

    ////////////////////////////////////////////////////////////////////////////////
    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_b)
        ce && ((fl.set & LIVE_MASK) != 8'h00) |=>
            ((fl.flags & ($past(fl.set) & LIVE_MASK)) == ($past(fl.set) & LIVE_MASK));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost against clear");

endmodule : usbie_flags
`default_nettype wire

// ===== usb_interrupt_enable_regs_test.sv
// Self-checking bench for the USB interrupt-enable register block, with a reference model.
// Assumes usbie_pkg and the design files are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module usb_interrupt_enable_regs_test;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [7:0] reg_rdata;
    logic irq;
    logic [7:0] en_out_m, en_cmn_m, fl_out_m, fl_cmn_m, rd_m;
    logic irq_m;
    logic chk_on = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int op;
    logic [7:0] ea, fa, bm;
    logic [7:0] amap [6] = '{8'h04, 8'h06, 8'h09, 8'h0B, 8'h0A, 8'hFF};

    usbie_top usbie_top_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .out_ep1_event(ev[4]),
        .out_ep2_event(ev[5]),
        .out_ep3_event(ev[6]),
        .frame_start_event(ev[3]),
        .bus_reset_event(ev[2]),
        .resume_event(ev[1]),
        .suspend_event(ev[0]),
        .irq(irq)
    );

    always #25 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model; it reads the inputs before the bench's edge updates land, as the design does.
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            en_out_m = usbie_pkg::OUT_EN_RESET;
            en_cmn_m = 8'h06;
            fl_out_m = 8'h00;
            fl_cmn_m = 8'h00;
            rd_m = 8'h00;
            irq_m = 1'b0;
        end else if (ce) begin
            irq_m = |((fl_out_m & en_out_m) | (fl_cmn_m & en_cmn_m));
            rd_m = 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    usbie_pkg::OUT_FLAG_ADDR: rd_m = fl_out_m;
                    usbie_pkg::CMN_FLAG_ADDR: rd_m = fl_cmn_m;
                    usbie_pkg::OUT_EN_ADDR: rd_m = en_out_m;
                    usbie_pkg::CMN_EN_ADDR: rd_m = en_cmn_m;
                    default: rd_m = 8'h00;
                endcase
            end
            if (reg_wr && reg_addr == usbie_pkg::OUT_FLAG_ADDR) fl_out_m = fl_out_m & ~reg_wdata;
            if (reg_wr && reg_addr == usbie_pkg::CMN_FLAG_ADDR) fl_cmn_m = fl_cmn_m & ~reg_wdata;
            if (reg_wr && reg_addr == usbie_pkg::OUT_EN_ADDR) en_out_m = reg_wdata & 8'h0E;
            if (reg_wr && reg_addr == usbie_pkg::CMN_EN_ADDR) en_cmn_m = reg_wdata & 8'h0F;
            fl_out_m = fl_out_m | {4'h0, ev[6:4], 1'b0};
            fl_cmn_m = fl_cmn_m | {4'h0, ev[3:0]};
        end
    end

    always @(negedge ref_clk) begin
        if (chk_on) begin
            `CHK("irq", irq_m, irq)
            `CHK("reg_rdata", rd_m, reg_rdata)
        end
    end

    // A hang must still end in the closing report rather than run forever.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev <= 7'h01 << i;
        @(posedge ref_clk);
        ev <= 7'h00;
    endtask : pulse

    task automatic look(input logic e, input string nm);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(nm, e, irq)
    endtask : look

    task automatic read_all;
        foreach (amap[k]) rd(amap[k]);
    endtask : read_all

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1E1D));
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk_on = 1'b1;
        read_all();
        $display("test reset_values done");
        wr(usbie_pkg::OUT_EN_ADDR, 8'hFF);
        wr(usbie_pkg::CMN_EN_ADDR, 8'hFF);
        wr(8'h0A, 8'hFF);
        read_all();
        wr(usbie_pkg::OUT_EN_ADDR, 8'h00);
        wr(usbie_pkg::CMN_EN_ADDR, 8'h00);
        read_all();
        $display("test enable_access done");
        for (int i = 0; i < 7; i++) begin
            ea = (i < 4) ? usbie_pkg::CMN_EN_ADDR : usbie_pkg::OUT_EN_ADDR;
            fa = (i < 4) ? usbie_pkg::CMN_FLAG_ADDR : usbie_pkg::OUT_FLAG_ADDR;
            bm = (i < 4) ? (8'h01 << i) : (8'h01 << (i - 3));
            pulse(i);
            rd(fa);
            look(1'b0, "irq_masked");
            wr(ea, bm);
            look(1'b1, "irq_enabled");
            wr(fa, bm);
            look(1'b0, "irq_cleared");
            wr(ea, 8'h00);
        end
        $display("test event_gating done");
        // Random traffic mixes events, clear writes, enable writes and frozen cycles.
        for (int n = 0; n < 400; n++) begin
            @(posedge ref_clk);
            op = $urandom % 4;
            ev <= 7'($urandom & $urandom);
            ce <= ($urandom % 8) != 0;
            reg_addr <= amap[$urandom % 6];
            reg_wdata <= 8'($urandom);
            reg_wr <= (op == 0);
            reg_rd <= (op == 1);
        end
        @(posedge ref_clk);
        ev <= 7'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        ce <= 1'b1;
        read_all();
        $display("test random_traffic done");
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        read_all();
        $display("test mid_reset done");
        repeat (3) @(posedge ref_clk);
        complete_run();
    end
endmodule : usb_interrupt_enable_regs_test
`default_nettype wire
